// >>> design/nvs_pkg.sv
/*
 * Shared constants and types for the serial nonvolatile SRAM command logic.
 * Assumes a single system clock that oversamples all serial pins.
 */
package nvs_pkg;

   // Command opcodes.
   localparam logic [7:0] OPC_STATUS_READ      = 8'h05;
   localparam logic [7:0] OPC_FAST_STATUS_READ = 8'h09;
   localparam logic [7:0] OPC_STATUS_WRITE     = 8'h01;
   localparam logic [7:0] OPC_SET_WRITE_LATCH  = 8'h06;
   localparam logic [7:0] OPC_CLR_WRITE_LATCH  = 8'h04;
   localparam logic [7:0] OPC_READ             = 8'h03;
   localparam logic [7:0] OPC_FAST_READ        = 8'h0b;
   localparam logic [7:0] OPC_WRITE            = 8'h02;
   localparam logic [7:0] OPC_STORE            = 8'h3c;
   localparam logic [7:0] OPC_RECALL           = 8'h60;
   localparam logic [7:0] OPC_AUTOSAVE_ON      = 8'h59;
   localparam logic [7:0] OPC_AUTOSAVE_OFF     = 8'h19;
   localparam logic [7:0] OPC_SERIAL_WRITE     = 8'hc2;

   // Status byte field positions.
   localparam int SR_READY      = 0;
   localparam int SR_WRITE_LATCH = 1;
   localparam int SR_BLOCK_LOW  = 2;
   localparam int SR_BLOCK_HIGH = 3;
   localparam int SR_SERIAL_LOCK = 6;
   localparam int SR_PIN_ENABLE = 7;

   localparam logic [7:0] SR_WRITE_MASK  = 8'hcc;
   localparam logic [7:0] SR_RESET       = 8'h00;
   localparam logic [7:0] SR_NV_RESET    = 8'h00;
   localparam logic       AUTOSAVE_RESET = 1'b1;

   // Array geometry and block protection bases.
   localparam int          ADDR_W         = 15;
   localparam int          ARRAY_DEPTH    = 32768;
   localparam logic [14:0] PROT_BASE_QTR  = 15'h6000;
   localparam logic [14:0] PROT_BASE_HALF = 15'h4000;

   // Bit counter end values.
   localparam logic [3:0] CNT_BYTE_LAST = 4'h7;
   localparam logic [3:0] CNT_ADDR_LAST = 4'hf;

   // Synchronised pin indices and their reset levels.
   localparam int         PIN_N     = 4;
   localparam int         PIN_CS    = 0;
   localparam int         PIN_SCK   = 1;
   localparam int         PIN_SI    = 2;
   localparam int         PIN_WP    = 3;
   localparam logic [3:0] PIN_RESET = 4'h9;

   // Clock rate of the sampling clock.
   localparam int SYS_CLK_HZ = 10000000;

   typedef enum logic [2:0] {
      ST_OPCODE    = 3'h0,
      ST_ADDR      = 3'h1,
      ST_DUMMY     = 3'h3,
      ST_SHIFT_OUT = 3'h2,
      ST_STATUS_IN = 3'h6,
      ST_IGNORE    = 3'h7
   } nvs_state_t;

   typedef enum logic [2:0] {
      END_NONE     = 3'h0,
      END_SET      = 3'h1,
      END_CLR      = 3'h2,
      END_STORE    = 3'h3,
      END_RECALL   = 3'h4,
      END_AS_ON    = 3'h5,
      END_AS_OFF   = 3'h6
   } nvs_end_t;

   typedef struct packed {
      nvs_state_t  st;
      nvs_end_t    end_act;
      logic [3:0]  icnt;
      logic [15:0] sh;
      logic        fast;
      logic        src_array;
      logic [2:0]  ocnt;
      logic [7:0]  obuf;
      logic [14:0] addr;
      logic        so;
      logic        so_oe;
      logic [7:0]  stat;
      logic [7:0]  nv_stat;
      logic        sw_permit;
      logic        busy_d;
      logic        store_req;
      logic        recall_req;
      logic        autosave;
   } nvs_core_t;

endpackage : nvs_pkg

// >>> design/nvs_pin_if.sv
/*
 * Carrier for the cleaned serial pin levels and their edge pulses.
 * Assumes producer and consumer share the system clock.
 */
interface nvs_pin_if;
   logic [3:0] lvl;
   logic [3:0] rise;
   logic [3:0] fall;

   modport src (output lvl, output rise, output fall);
   modport dst (input lvl, input rise, input fall);
endinterface : nvs_pin_if

// >>> design/nvs_pin_sync.sv
/*
 * Three-stage synchroniser and edge finder for the serial pins.
 * Assumes pins are asynchronous to the system clock and change slowly
 * compared with it.
 */
module nvs_pin_sync
   import nvs_pkg::*;
(
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   input  wire logic [3:0]   pins_i,
   nvs_pin_if.src            pins
);

   typedef struct packed {
      logic [3:0] s1;
      logic [3:0] s2;
      logic [3:0] s3;
      logic [3:0] lvl;
      logic [3:0] rise;
      logic [3:0] fall;
   } nvs_sync_t;

   nvs_sync_t q_ff;
   nvs_sync_t nxt_q;

   // The first stage feeds only the second; a level is accepted once
   // the second and third stages agree, which filters a late glitch.
   always_comb begin
      nxt_q    = q_ff;
      nxt_q.s1 = pins_i;
      nxt_q.s2 = q_ff.s1;
      nxt_q.s3 = q_ff.s2;
      for (int i = 0; i < PIN_N; i++) begin
         if (q_ff.s2[i] == q_ff.s3[i]) begin
            nxt_q.lvl[i] = q_ff.s3[i];
         end
      end
      nxt_q.rise = nxt_q.lvl & ~q_ff.lvl;
      nxt_q.fall = ~nxt_q.lvl & q_ff.lvl;
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         q_ff <= '{s1: PIN_RESET, s2: PIN_RESET, s3: PIN_RESET,
                   lvl: PIN_RESET, rise: 4'h0, fall: 4'h0};
      end else begin
         q_ff <= nxt_q;
      end
   end

   assign pins.lvl  = q_ff.lvl;
   assign pins.rise = q_ff.rise;
   assign pins.fall = q_ff.fall;

endmodule : nvs_pin_sync

// >>> design/nvs_spi_core.sv
/*
 * Serial command logic of a byte-wide nonvolatile SRAM: status register,
 * write latch, block and pin write protection, and array read bursts.
 * Assumes the serial pins are oversampled by SYS_CLK_I at least eight
 * times per serial clock period, and that the store engine reports its
 * busy state on STORE_BUSY_I in this clock domain.
 */
// What this block does
// - Fast status read: opcode, dummy byte, status
// - Ready bit high during store or recall
// - Status write changes only bits 2,3,6,7
// - Status write needs latch, eight data bits
// - Protect pin ignored unless pin-enable bit set
// - Status values become nonvolatile only on store
// - Write-class commands require the write latch
// - Write latch cleared at power-up
// - Without latch, write commands ignored until deselect
// - Set-latch command sets the write latch
// - Write-class completion clears the write latch
// - Clear-latch command clears latch at deselect
// - Block-protect bits select protected array range
// - Low pin plus enable bit refuses status writes
// - Pin falling mid-frame leaves status write intact
// - No array read starts during store or recall
// - Read: opcode, two address bytes, MSB first out
// - Read burst increments and wraps at top address
// - Set-latch opcode is 0x06
// - Clear-latch opcode is 0x04
// - Normal read opcode is 0x03
// - Fast status read opcode is 0x09
module nvs_spi_core
   import nvs_pkg::*;
(
   input  wire logic                 SYS_CLK_I,
   input  wire logic                 RST_I,
   input  wire logic                 CS_N_I,
   input  wire logic                 SCK_I,
   input  wire logic                 SI_I,
   input  wire logic                 WP_N_I,
   input  wire logic                 STORE_BUSY_I,
   input  wire logic                 MEM_WR_EN_I,
   input  wire logic [14:0]          MEM_WR_ADDR_I,
   input  wire logic [7:0]           MEM_WR_DATA_I,
   output logic                      SO_O,
   output logic                      SO_OE_O,
   output logic [7:0]                STATUS_O,
   output logic [7:0]                STATUS_NV_O,
   output logic                      STORE_REQ_O,
   output logic                      RECALL_REQ_O,
   output logic                      AUTOSAVE_EN_O
);
   import nvs_pkg::*;

   nvs_pin_if  pins ();
   nvs_core_t  q_ff;
   nvs_core_t  nxt_q;
   logic [7:0] mem [ARRAY_DEPTH];
   logic [7:0] mem_rd;

   // True when the address falls inside the range chosen by the
   // two block-protect bits.
   function automatic logic blk_protected(input logic [14:0] a,
                                          input logic [1:0]  bp);
      logic hit;
      hit = 1'b0;
      case (bp)
         2'h0: hit = 1'b0;
         2'h1: hit = (a >= PROT_BASE_QTR);
         2'h2: hit = (a >= PROT_BASE_HALF);
         2'h3: hit = 1'b1;
         default: hit = 1'b1;
      endcase
      return hit;
   endfunction : blk_protected

   nvs_pin_sync u_sync (
      .clk_i  (SYS_CLK_I),
      .rst_i  (RST_I),
      .pins_i ({WP_N_I, SI_I, SCK_I, CS_N_I}),
      .pins   (pins)
   );

   // The array keeps no reset; the external write path is refused
   // inside the protected range so a protected byte is read only.
   always_ff @(posedge SYS_CLK_I) begin
      if (MEM_WR_EN_I &&
          !blk_protected(MEM_WR_ADDR_I,
                         {q_ff.stat[SR_BLOCK_HIGH],
                          q_ff.stat[SR_BLOCK_LOW]})) begin
         mem[MEM_WR_ADDR_I] <= MEM_WR_DATA_I;
      end
   end

   assign mem_rd = mem[q_ff.addr];

   always_comb begin
      logic [15:0] sh_in;
      logic [7:0]  opc;
      logic [7:0]  byte_out;
      logic [7:0]  wr_data;
      logic        wel;
      sh_in    = {q_ff.sh[14:0], pins.lvl[PIN_SI]};
      opc      = sh_in[7:0];
      byte_out = q_ff.obuf;
      wr_data  = sh_in[7:0];
      wel      = q_ff.stat[SR_WRITE_LATCH];
      nxt_q    = q_ff;
      nxt_q.store_req  = 1'b0;
      nxt_q.recall_req = 1'b0;

      // Ready bit follows the store engine every cycle.
      nxt_q.stat[SR_READY] = STORE_BUSY_I;
      nxt_q.busy_d         = STORE_BUSY_I;

      // Snapshot the writable bits when a store begins; a recall
      // brings them back from the snapshot.
      if (STORE_BUSY_I && !q_ff.busy_d) begin
         nxt_q.nv_stat = q_ff.stat & SR_WRITE_MASK;
      end
      if (q_ff.recall_req) begin
         nxt_q.stat = (q_ff.stat & ~SR_WRITE_MASK) |
                      (q_ff.nv_stat & SR_WRITE_MASK);
         nxt_q.stat[SR_READY] = STORE_BUSY_I;
      end

      if (pins.rise[PIN_CS] || pins.fall[PIN_CS]) begin
         // Deselect executes the pending latch or special action and
         // returns the decoder to await a fresh opcode.
         if (pins.rise[PIN_CS]) begin
            case (q_ff.end_act)
               END_SET: nxt_q.stat[SR_WRITE_LATCH] = 1'b1;
               END_CLR: nxt_q.stat[SR_WRITE_LATCH] = 1'b0;
               END_STORE: begin
                  nxt_q.stat[SR_WRITE_LATCH] = 1'b0;
                  nxt_q.store_req = 1'b1;
               end
               END_RECALL: begin
                  nxt_q.stat[SR_WRITE_LATCH] = 1'b0;
                  nxt_q.recall_req = 1'b1;
               end
               END_AS_ON: begin
                  nxt_q.stat[SR_WRITE_LATCH] = 1'b0;
                  nxt_q.autosave = 1'b1;
               end
               END_AS_OFF: begin
                  nxt_q.stat[SR_WRITE_LATCH] = 1'b0;
                  nxt_q.autosave = 1'b0;
               end
               default: nxt_q.stat[SR_WRITE_LATCH] = wel;
            endcase
         end
         nxt_q.st      = ST_OPCODE;
         nxt_q.icnt    = 4'h0;
         nxt_q.end_act = END_NONE;
         nxt_q.so_oe   = 1'b0;
         nxt_q.ocnt    = 3'h0;
      end else if (!pins.lvl[PIN_CS]) begin
         if (pins.rise[PIN_SCK]) begin
            // Input is taken on rising serial clock in either mode.
            nxt_q.sh   = sh_in;
            nxt_q.icnt = 4'(q_ff.icnt + 4'h1);
            case (q_ff.st)
               ST_OPCODE: begin
                  if (q_ff.icnt == CNT_BYTE_LAST) begin
                     nxt_q.icnt = 4'h0;
                     nxt_q.st   = ST_IGNORE;
                     nxt_q.ocnt = 3'h0;
                     case (opc)
                        OPC_STATUS_READ: begin
                           nxt_q.src_array = 1'b0;
                           nxt_q.st        = ST_SHIFT_OUT;
                        end
                        OPC_FAST_STATUS_READ: begin
                           nxt_q.src_array = 1'b0;
                           nxt_q.st        = ST_DUMMY;
                        end
                        OPC_READ, OPC_FAST_READ: begin
                           nxt_q.src_array = 1'b1;
                           nxt_q.fast      = (opc == OPC_FAST_READ);
                           if (!STORE_BUSY_I) begin
                              nxt_q.st = ST_ADDR;
                           end
                        end
                        OPC_SET_WRITE_LATCH: begin
                           nxt_q.end_act = END_SET;
                        end
                        OPC_CLR_WRITE_LATCH: begin
                           nxt_q.end_act = END_CLR;
                        end
                        OPC_STATUS_WRITE: begin
                           if (wel) begin
                              nxt_q.end_act = END_CLR;
                              nxt_q.st      = ST_STATUS_IN;
                              // Permission is frozen here so a later pin
                              // fall cannot spoil the write in flight.
                              nxt_q.sw_permit =
                                 !(q_ff.stat[SR_PIN_ENABLE] &&
                                   !pins.lvl[PIN_WP]);
                           end
                        end
                        OPC_WRITE, OPC_SERIAL_WRITE: begin
                           if (wel) begin
                              nxt_q.end_act = END_CLR;
                           end
                        end
                        OPC_STORE: begin
                           if (wel) nxt_q.end_act = END_STORE;
                        end
                        OPC_RECALL: begin
                           if (wel) nxt_q.end_act = END_RECALL;
                        end
                        OPC_AUTOSAVE_ON: begin
                           if (wel) nxt_q.end_act = END_AS_ON;
                        end
                        OPC_AUTOSAVE_OFF: begin
                           if (wel) nxt_q.end_act = END_AS_OFF;
                        end
                        default: nxt_q.st = ST_IGNORE;
                     endcase
                  end
               end
               ST_ADDR: begin
                  if (q_ff.icnt == CNT_ADDR_LAST) begin
                     // The top address bit is dropped by the width.
                     nxt_q.addr = sh_in[14:0];
                     nxt_q.icnt = 4'h0;
                     nxt_q.st   = q_ff.fast ? ST_DUMMY : ST_SHIFT_OUT;
                  end
               end
               ST_DUMMY: begin
                  if (q_ff.icnt == CNT_BYTE_LAST) begin
                     nxt_q.icnt = 4'h0;
                     nxt_q.st   = ST_SHIFT_OUT;
                  end
               end
               ST_STATUS_IN: begin
                  if (q_ff.icnt == CNT_BYTE_LAST) begin
                     if (q_ff.sw_permit) begin
                        nxt_q.stat = (q_ff.stat & ~SR_WRITE_MASK) |
                                     (wr_data & SR_WRITE_MASK);
                        // A status write can set the lock bit but never clear it.
                        nxt_q.stat[SR_SERIAL_LOCK] =
                           q_ff.stat[SR_SERIAL_LOCK] |
                           wr_data[SR_SERIAL_LOCK];
                        nxt_q.stat[SR_READY] = STORE_BUSY_I;
                     end
                     nxt_q.st = ST_IGNORE;
                  end
               end
               ST_SHIFT_OUT, ST_IGNORE: begin
                  // Serial input is ignored while data goes out.
                  nxt_q.icnt = 4'h0;
               end
               default: nxt_q.st = ST_IGNORE;
            endcase
         end
         if (pins.fall[PIN_SCK] && q_ff.st == ST_SHIFT_OUT) begin
            // A new byte is fetched as its first bit is driven, so a
            // status poll shows the ready bit live on every byte.
            if (q_ff.ocnt == 3'h0) begin
               byte_out = q_ff.src_array ? mem_rd : q_ff.stat;
               if (q_ff.src_array) begin
                  // The address width makes the top wrap to zero.
                  nxt_q.addr = 15'(q_ff.addr + 15'h1);
               end
            end
            nxt_q.so    = byte_out[7];
            nxt_q.obuf  = {byte_out[6:0], 1'b0};
            nxt_q.ocnt  = 3'(q_ff.ocnt + 3'h1);
            nxt_q.so_oe = 1'b1;
         end
      end
   end

   always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         q_ff <= '{st: ST_OPCODE, end_act: END_NONE, icnt: 4'h0,
                   sh: 16'h0000, fast: 1'b0, src_array: 1'b0,
                   ocnt: 3'h0, obuf: 8'h00, addr: 15'h0000,
                   so: 1'b0, so_oe: 1'b0,
                   stat: SR_RESET,
                   nv_stat: SR_NV_RESET, sw_permit: 1'b0,
                   busy_d: 1'b0, store_req: 1'b0, recall_req: 1'b0,
                   autosave: AUTOSAVE_RESET};
      end else begin
         q_ff <= nxt_q;
      end
   end

   assign SO_O          = q_ff.so;
   assign SO_OE_O       = q_ff.so_oe;
   assign STATUS_O      = q_ff.stat;
   assign STATUS_NV_O   = q_ff.nv_stat;
   assign STORE_REQ_O   = q_ff.store_req;
   assign RECALL_REQ_O  = q_ff.recall_req;
   assign AUTOSAVE_EN_O = q_ff.autosave;

endmodule : nvs_spi_core

// >>> tb/nvs_spi_checker.sv
/*
 * Concurrent checks on the ports of the serial SRAM command logic.
 * Assumes it is bound to nvs_spi_core and sees that module's ports.
 */
module nvs_spi_checker (
   input wire logic       SYS_CLK_I,
   input wire logic       RST_I,
   input wire logic       CS_N_I,
   input wire logic       WP_N_I,
   input wire logic       STORE_BUSY_I,
   input wire logic       SO_OE_O,
   input wire logic [7:0] STATUS_O,
   input wire logic [7:0] STATUS_NV_O,
   input wire logic       STORE_REQ_O,
   input wire logic       RECALL_REQ_O
);
   timeunit 1ns;
   timeprecision 1ns;

   default clocking cb @(posedge SYS_CLK_I); endclocking
   default disable iff (RST_I);

   // The lock is frozen at frame start, so a pin fall mid-frame is ignored.
   logic lock_ff;
   logic nxt_lock;

   always_comb nxt_lock = CS_N_I ? (STATUS_O[7] & ~WP_N_I) : lock_ff;

   always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
      if (RST_I)
         lock_ff <= 1'b0;
      else
         lock_ff <= nxt_lock;
   end

   sequence s_deselected;
      CS_N_I [*6];
   endsequence

   sequence s_special;
      STORE_REQ_O || RECALL_REQ_O;
   endsequence

   a_ready_tracks: assert property (
      1'b1 |=> STATUS_O[0] == $past(STORE_BUSY_I))
      else $error("Ready bit does not follow busy.");
   a_unused_zero: assert property (
      STATUS_O[5:4] == 2'b00)
      else $error("Unused status bits not zero.");
   a_latch_deselect: assert property (
      !$stable(STATUS_O[1]) |-> CS_N_I)
      else $error("Write latch changed inside a frame.");
   a_status_gated: assert property (
      !$stable(STATUS_O & 8'hcc) && !$past(RECALL_REQ_O)
      && !$past(RECALL_REQ_O, 2) |-> $past(STATUS_O[1]))
      else $error("Status changed without the write latch.");
   a_pin_lock: assert property (
      lock_ff && !CS_N_I |=> $stable(STATUS_O & 8'hcc))
      else $error("Status written while pin protected.");
   a_special_latch: assert property (
      s_special |-> $past(STATUS_O[1]) || $past(STATUS_O[1], 2))
      else $error("Store or recall without the write latch.");
   a_special_clears: assert property (
      s_special |-> ##[0:2] !STATUS_O[1])
      else $error("Write latch not cleared after command.");
   a_idle_quiet: assert property (
      s_deselected |-> !SO_OE_O)
      else $error("Serial output driven while deselected.");
   a_nv_on_store: assert property (
      !$stable(STATUS_NV_O) |-> $past(STORE_BUSY_I))
      else $error("Nonvolatile status changed without a store.");
endmodule : nvs_spi_checker

bind nvs_spi_core nvs_spi_checker u_chk (
   .SYS_CLK_I    (SYS_CLK_I),
   .RST_I        (RST_I),
   .CS_N_I       (CS_N_I),
   .WP_N_I       (WP_N_I),
   .STORE_BUSY_I (STORE_BUSY_I),
   .SO_OE_O      (SO_OE_O),
   .STATUS_O     (STATUS_O),
   .STATUS_NV_O  (STATUS_NV_O),
   .STORE_REQ_O  (STORE_REQ_O),
   .RECALL_REQ_O (RECALL_REQ_O)
);

// >>> tb/nvs_host_model.sv
/*
 * Behavioural serial host in clock mode 0 or 3 for the SRAM command logic.
 * Assumes a free-running bench clock; one serial bit takes eight periods.
 */
module nvs_host_model (
   input  wire logic clk_i,
   output logic      cs_n_o,
   output logic      sck_o,
   output logic      si_o,
   input  wire logic so_i
);
   timeunit 1ns;
   timeprecision 1ns;

   // Idle level of the serial clock: low for mode 0, high for mode 3.
   logic cpol = 1'b0;

   initial begin
      cs_n_o = 1'b1;
      sck_o  = 1'b0;
      si_o   = 1'b0;
   end

   // Shifts n bytes from the top of tx; so_i is taken mid high phase, where
   // it has settled one clock after the five-clock output delay.
   task automatic xfer(input int n, input logic [63:0] tx,
                       output logic [63:0] rx);
      rx = '0;
      // The clock settles at its idle level while still deselected, so a
      // mode change is never mistaken for a data edge.
      sck_o <= cpol;
      repeat (8) @(posedge clk_i);
      for (int k = 0; k < 8 * n; k++) begin
         @(posedge clk_i);
         cs_n_o <= 1'b0;
         sck_o  <= 1'b0;
         si_o   <= tx[63 - k];
         repeat (4) @(posedge clk_i);
         sck_o <= 1'b1;
         repeat (2) @(posedge clk_i);
         rx[63 - k] = so_i;
         @(posedge clk_i);
      end
      @(posedge clk_i);
      sck_o <= cpol;
      repeat (4) @(posedge clk_i);
      cs_n_o <= 1'b1;
      // A released data line flips so that a stale bit cannot pass.
      si_o   <= ~si_o;
      repeat (8) @(posedge clk_i);
   endtask : xfer
endmodule : nvs_host_model

// >>> tb/test_spi_nvram_protect_status_read.sv
/*
 * Self-checking bench for the serial SRAM command logic.
 * Assumes the host model and the bound checker are compiled with it.
 */
module test_spi_nvram_protect_status_read;
   timeunit 1ns;
   timeprecision 1ns;

   logic        clk, rst, cs_n, sck, si, so, so_oe, wp_n, busy;
   logic        mwe, stq, rcq, asv;
   logic [14:0] mwa;
   logic [7:0]  mwd, st, stnv;
   logic [63:0] rx;
   logic [7:0]  shadow [6];
   logic [14:0] probe [6] = '{15'h3fff, 15'h4000, 15'h5fff, 15'h6000,
                              15'h7fff, 15'h0000};
   logic [7:0]  ops [6] = '{8'h3c, 8'h60, 8'h19, 8'h59, 8'h02, 8'hc2};
   logic [5:0]  asv_exp = 6'b111011;
   int          error_cnt = 0, n_checks = 0, n_store = 0, n_recall = 0;
   int          oe_cnt = 0, base;

   nvs_spi_core dut (
      .SYS_CLK_I     (clk),
      .RST_I         (rst),
      .CS_N_I        (cs_n),
      .SCK_I         (sck),
      .SI_I          (si),
      .WP_N_I        (wp_n),
      .STORE_BUSY_I  (busy),
      .MEM_WR_EN_I   (mwe),
      .MEM_WR_ADDR_I (mwa),
      .MEM_WR_DATA_I (mwd),
      .SO_O          (so),
      .SO_OE_O       (so_oe),
      .STATUS_O      (st),
      .STATUS_NV_O   (stnv),
      .STORE_REQ_O   (stq),
      .RECALL_REQ_O  (rcq),
      .AUTOSAVE_EN_O (asv)
   );

   // A released output shows the inverse so that a stale bit cannot pass.
   nvs_host_model host (
      .clk_i  (clk),
      .cs_n_o (cs_n),
      .sck_o  (sck),
      .si_o   (si),
      .so_i   (so_oe ? so : ~so)
   );

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   always @(posedge clk) begin
      if (stq === 1'b1) n_store++;
      if (rcq === 1'b1) n_recall++;
      if (so_oe === 1'b1) oe_cnt++;
   end

   task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                      input string what);
      n_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH %0t %s: got %h want %h", $time, what, got, exp);
      end
   endtask : chk

   task automatic cmd(input logic [7:0] op);
      host.xfer(1, {op, 56'h0}, rx);
   endtask : cmd

   task automatic wr_status(input logic [7:0] v);
      cmd(8'h06);
      host.xfer(2, {8'h01, v, 48'h0}, rx);
   endtask : wr_status

   function automatic bit prot(input int lv, input logic [14:0] a);
      return lv == 3 || (lv == 2 && a >= 15'h4000)
             || (lv == 1 && a >= 15'h6000);
   endfunction : prot

   task automatic complete_run;
      $display("checks %0d mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : complete_run

   initial begin
      rst = 1'b1;
      wp_n = 1'b1;
      busy = 1'b0;
      mwe = 1'b0;
      mwa = '0;
      mwd = '0;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      repeat (4) @(posedge clk);
      chk(st, 8'h00, "power-up status");
      chk(8'(asv), 8'h01, "autosave at reset");
      host.xfer(2, {8'h01, 8'hcc, 48'h0}, rx);
      chk(st, 8'h00, "write without latch");
      cmd(8'h06);
      chk(st, 8'h02, "set latch");
      cmd(8'h04);
      chk(st, 8'h00, "clear latch");
      wr_status(8'hff);
      chk(st, 8'hcc, "status write");
      host.xfer(3, {8'h05, 56'h0}, rx);
      chk(rx[55:48], 8'hcc, "status read");
      host.xfer(3, {8'h09, 56'h0}, rx);
      chk(rx[47:40], 8'hcc, "fast status read");
      host.cpol <= 1'b1;
      host.xfer(3, {8'h05, 56'h0}, rx);
      chk(rx[55:48], 8'hcc, "status read idle-high clock");
      host.cpol <= 1'b0;
      wp_n <= 1'b0;
      wr_status(8'h00);
      chk(st, 8'hcc, "write while pin low");
      wp_n <= 1'b1;
      wr_status(8'h00);
      chk(st, 8'h40, "write while pin high");
      wp_n <= 1'b0;
      wr_status(8'h8c);
      chk(st, 8'hcc, "pin ignored when disabled");
      wp_n <= 1'b1;
      cmd(8'h06);
      fork
         host.xfer(2, {8'h01, 8'h44, 48'h0}, rx);
         begin
            repeat (100) @(posedge clk);
            wp_n <= 1'b0;
         end
      join
      chk(st, 8'h44, "pin falls mid-write");
      wp_n <= 1'b1;
      for (int lv = 0; lv < 4; lv++) begin
         wr_status(8'(lv << 2));
         for (int k = 0; k < 6; k++) begin
            @(posedge clk);
            mwe <= 1'b1;
            mwa <= probe[k];
            mwd <= 8'(lv * 16 + k);
            @(posedge clk);
            mwe <= 1'b0;
            if (!prot(lv, probe[k])) shadow[k] = 8'(lv * 16 + k);
         end
         for (int k = 0; k < 6; k += 2) begin
            host.xfer(5, {8'h03, 1'b1, probe[k], 40'h5aa55aa55a}, rx);
            chk(rx[39:32], shadow[k], "read data");
            chk(rx[31:24], shadow[k + 1], "burst next byte");
         end
      end
      host.xfer(5, {8'h0b, 1'b0, probe[0], 40'h0}, rx);
      chk(rx[31:24], shadow[0], "fast read after dummy");
      chk(stnv, 8'h00, "snapshot before store");
      base = oe_cnt;
      busy <= 1'b1;
      repeat (4) @(posedge clk);
      chk(st, 8'h4d, "ready while busy");
      chk(stnv, 8'h4c, "snapshot on store");
      host.xfer(4, {8'h03, 56'h0}, rx);
      chk(8'(oe_cnt - base), 8'h00, "read while busy");
      busy <= 1'b0;
      repeat (4) @(posedge clk);
      cmd(8'h3c);
      chk(8'(n_store), 8'h00, "store without latch");
      wr_status(8'h80);
      for (int k = 0; k < 6; k++) begin
         cmd(8'h06);
         cmd(ops[k]);
         chk({st[1], 6'h0, asv}, {7'h0, asv_exp[k]}, "special cmd");
      end
      chk(8'(n_store * 16 + n_recall), 8'h11, "store/recall pulses");
      chk(st, 8'h4c, "recall reload");
      complete_run();
   end

   initial begin
      repeat (30000) @(posedge clk);
      error_cnt++;
      $display("MISMATCH %0t watchdog expired", $time);
      complete_run();
   end
endmodule : test_spi_nvram_protect_status_read
